// file: hdl/pmwc_top.sv
// power mode and wakeup control with axi4-lite registers
// What this block does
// - 23 edge event lines each raise an interrupt request.
// - each line has its own edge choice and mask; masked lines raise nothing.
// - each unmasked trigger sets a readable pending bit.
// - lines 0..15 come from pins, the rest from internal sources.
// - low supply always holds the core in reset while it lasts.
// - the supply monitor interrupts on falling, rising or both crossings.
// - the supply monitor is off until software enables it.
// - the regulator has normal, low-power and power-down modes.
// - any reset leaves the regulator in normal mode.
// - normal in run and sleep, low-power only in deep, off in standby.
// - sleep stops only the cpu clock and any unmasked event wakes it.
// - deepsleep stops core clocks, pll and fast oscillators, keeping state.
// - any edge line wakes the device from deepsleep.
// - standby powers off the core domain; only always-on state survives.
// - standby ends only on reset pin, watchdog, low supply, wakeup pin rise or calendar alarm.
// - low-power modes never stop the calendar unit, watchdog or their clocks.
`timescale 1ns/1ns
`include "pmwc_cfg.svh"
module pmwc_top
#(
    parameter int RST_CYC = `PMWC_RST_CYC
)
(
    input  wire logic        i_mclk,           // system clock, 20 MHz
    input  wire logic        i_rst,            // synchronous reset, active high
    input  wire logic        i_ce,             // clock enable, freezes all state
    input  wire logic [15:0] i_pin_lines,      // gpio edge event sources
    input  wire logic        i_low_supply,     // low-supply indication, async
    input  wire logic        i_supply_below,   // supply below monitor threshold, async
    input  wire logic        i_cal_alarm,      // calendar alarm, async
    input  wire logic        i_usb_wake,       // usb port wake event, async
    input  wire logic        i_cmp_wake,       // comparator wake event, async
    input  wire logic [2:0]  i_int_lines,      // spare internal event sources, async
    input  wire logic        i_reset_pin_n,    // external reset pin, active low, async
    input  wire logic        i_wdog_reset,     // independent watchdog reset, async
    input  wire logic        i_wakeup_pin,     // wakeup pin, async
    input  wire logic        i_sleep_req,      // processor wait-for-interrupt pulse
    input  wire logic        i_awvalid,        // axi write address valid
    output logic             o_awready,        // axi write address ready
    input  wire logic [7:0]  i_awaddr,         // axi write address
    input  wire logic        i_wvalid,         // axi write data valid
    output logic             o_wready,         // axi write data ready
    input  wire logic [31:0] i_wdata,          // axi write data
    input  wire logic [3:0]  i_wstrb,          // axi write strobes
    output logic             o_bvalid,         // axi write response valid
    input  wire logic        i_bready,         // axi write response ready
    output logic [1:0]       o_bresp,          // axi write response
    input  wire logic        i_arvalid,        // axi read address valid
    output logic             o_arready,        // axi read address ready
    input  wire logic [7:0]  i_araddr,         // axi read address
    output logic             o_rvalid,         // axi read data valid
    input  wire logic        i_rready,         // axi read data ready
    output logic [31:0]      o_rdata,          // axi read data
    output logic [1:0]       o_rresp,          // axi read response
    output logic [22:0]      o_line_irq,       // per-line interrupt requests
    output logic             o_irq,            // power interrupt, level
    output logic             o_core_rst,       // core domain reset, active high
    output logic             o_cpu_clk_en,     // processor clock enable
    output logic             o_core_clk_en,    // core domain clocks enable
    output logic             o_fast_osc_en,    // pll and fast oscillators enable
    output logic [1:0]       o_reg_mode,       // regulator mode
    output logic             o_aon_clk_en,     // calendar/watchdog clock sources
    output logic             o_standby         // standby active to always-on logic
);

    localparam int NL = `PMWC_NUM_LINES;

    // two-flop synchronisers for async inputs
    logic [29:0] sync1;
    logic [29:0] sync2;
    logic [29:0] async_in;
    assign async_in = {i_wakeup_pin, i_wdog_reset, ~i_reset_pin_n, i_supply_below, i_low_supply,
                       i_int_lines, i_cmp_wake, i_usb_wake, i_cal_alarm, 3'h0, i_pin_lines};

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            sync1 <= 30'h0;
            sync2 <= 30'h0;
        end
        else if (i_ce)
        begin
            sync1 <= async_in;
            sync2 <= sync1;
        end
    end

    pmwc_pkg::pmwc_state_s st;
    pmwc_pkg::pmwc_state_s next_st;

    // byte-lane merge of a write into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [22:0] lines;
    logic [22:0] edge_hit;
    logic        low_sup;
    logic        below;
    logic        pin_rst;
    logic        wd_rst;
    logic        wk_pin;
    logic        do_write;
    logic [31:0] wv;
    logic [1:0]  mon_ev;
    logic        any_pend;
    logic        stby_wake;

    // event lines: pins low, internal sources above
    always_comb
    begin
        lines = {sync2[24:22], sync2[21:19], sync2[18], 16'h0};
        lines[15:0] = sync2[15:0];
        lines[`PMWC_LINE_SUPPLY] = st.ctl[`PMWC_CTL_MON_EN] & sync2[26];
        low_sup = sync2[25];
        below   = sync2[26];
        pin_rst = sync2[27];
        wd_rst  = sync2[28];
        wk_pin  = sync2[29];
    end

    // main state update
    always_comb
    begin
        next_st  = st;
        wv       = 32'h0;
        do_write = 1'b0;
        edge_hit = 23'h0;
        mon_ev   = 2'h0;
        any_pend = 1'b0;
        stby_wake = 1'b0;

        // per-line edge detect
        next_st.line_q = lines;
        edge_hit = ((lines & ~st.line_q & st.rise) | (~lines & st.line_q & st.fall)) & st.mask;

        // supply monitor edges, only while enabled
        next_st.mon_q = below;
        if (st.ctl[`PMWC_CTL_MON_EN])
        begin
            mon_ev[0] = below & ~st.mon_q & st.ctl[`PMWC_CTL_MON_FALL];
            mon_ev[1] = ~below & st.mon_q & st.ctl[`PMWC_CTL_MON_RISE];
        end
        next_st.wk_q = wk_pin;

        // axi write: address and data latched in either order
        if (i_awvalid && !st.awvalid_done)
        begin
            next_st.awvalid_done = 1'b1;
            next_st.waddr = i_awaddr;
        end
        if (i_wvalid && !st.wvalid_done)
        begin
            next_st.wvalid_done = 1'b1;
            next_st.wdata = merge(32'h0, i_wdata, i_wstrb);
        end
        if (st.awvalid_done && st.wvalid_done && !st.bvalid)
        begin
            do_write = 1'b1;
            wv = st.wdata;
            next_st.bvalid = 1'b1;
            next_st.bresp = 2'h0;
            next_st.awvalid_done = 1'b0;
            next_st.wvalid_done = 1'b0;
            case (st.waddr)
                `PMWC_OFS_MASK:    next_st.mask = wv[22:0];
                `PMWC_OFS_RISE:    next_st.rise = wv[22:0];
                `PMWC_OFS_FALL:    next_st.fall = wv[22:0];
                `PMWC_OFS_PEND:    next_st.pend = st.pend & ~wv[22:0];
                `PMWC_OFS_PWRCTL:  next_st.ctl = wv[5:0];
                `PMWC_OFS_PWRSTAT: ;
                `PMWC_OFS_IRQSTAT: next_st.irq_st = st.irq_st & ~wv[1:0];
                `PMWC_OFS_IRQMASK: next_st.irq_mk = wv[1:0];
                default:           next_st.bresp = 2'h2;
            endcase
        end
        if (st.bvalid && i_bready)
        begin
            next_st.bvalid = 1'b0;
        end

        // sticky flags: a new event wins over a clear in the same cycle
        next_st.pend = next_st.pend | edge_hit;
        next_st.irq_st = next_st.irq_st | mon_ev;
        any_pend = |st.pend;

        // axi read
        if (i_arvalid && !st.rvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = 2'h0;
            case (i_araddr)
                `PMWC_OFS_MASK:    next_st.rdata = {9'h0, st.mask};
                `PMWC_OFS_RISE:    next_st.rdata = {9'h0, st.rise};
                `PMWC_OFS_FALL:    next_st.rdata = {9'h0, st.fall};
                `PMWC_OFS_PEND:    next_st.rdata = {9'h0, st.pend};
                `PMWC_OFS_PWRCTL:  next_st.rdata = {26'h0, st.ctl};
                `PMWC_OFS_PWRSTAT: next_st.rdata = {27'h0, below, st.reg_mode, st.mode == pmwc_pkg::PM_DEEP,
                                                    st.mode == pmwc_pkg::PM_SLEEP};
                `PMWC_OFS_IRQSTAT: next_st.rdata = {30'h0, st.irq_st};
                `PMWC_OFS_IRQMASK: next_st.rdata = {30'h0, st.irq_mk};
                default:
                begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = 2'h2;
                end
            endcase
        end
        if (st.rvalid && i_rready)
        begin
            next_st.rvalid = 1'b0;
        end

        // power mode sequencer
        stby_wake = pin_rst | wd_rst | (wk_pin & ~st.wk_q) | sync2[19];
        case (st.mode)
            pmwc_pkg::PM_RESET:
            begin
                // reset sequence from the last cause
                next_st.reg_mode = pmwc_pkg::REG_NORMAL;
                next_st.core_rst = 1'b1;
                next_st.fast_osc_en = 1'b1;
                next_st.core_clk_en = 1'b1;
                next_st.cpu_clk_en = 1'b0;
                if (st.rst_cnt == 16'(RST_CYC - 1))
                begin
                    next_st.mode = pmwc_pkg::PM_RUN;
                    next_st.core_rst = 1'b0;
                    next_st.cpu_clk_en = 1'b1;
                end
                else
                begin
                    next_st.rst_cnt = st.rst_cnt + 16'h1;
                end
            end
            pmwc_pkg::PM_RUN:
            begin
                if (i_sleep_req)
                begin
                    if (st.ctl[`PMWC_CTL_STBY])
                    begin
                        next_st.mode = pmwc_pkg::PM_STANDBY;
                        next_st.reg_mode = pmwc_pkg::REG_OFF;
                        next_st.fast_osc_en = 1'b0;
                        next_st.core_clk_en = 1'b0;
                        next_st.cpu_clk_en = 1'b0;
                        next_st.core_rst = 1'b1;
                    end
                    else if (st.ctl[`PMWC_CTL_DEEP])
                    begin
                        next_st.mode = pmwc_pkg::PM_DEEP;
                        next_st.cpu_clk_en = 1'b0;
                        next_st.core_clk_en = 1'b0;
                        next_st.fast_osc_en = 1'b0;
                        next_st.reg_mode = st.ctl[`PMWC_CTL_LPREG] ? pmwc_pkg::REG_LOWPWR
                                                                    : pmwc_pkg::REG_NORMAL;
                    end
                    else
                    begin
                        next_st.mode = pmwc_pkg::PM_SLEEP;
                        next_st.cpu_clk_en = 1'b0;
                    end
                end
            end
            pmwc_pkg::PM_SLEEP:
            begin
                // peripherals keep running; any pending event or unmasked flag wakes the cpu
                if (any_pend || |edge_hit || |(st.irq_st & st.irq_mk))
                begin
                    next_st.mode = pmwc_pkg::PM_RUN;
                    next_st.cpu_clk_en = 1'b1;
                end
            end
            pmwc_pkg::PM_DEEP:
            begin
                // any line change wakes, mask ignored; raw edge saves a cycle
                if (|(lines ^ st.line_q))
                begin
                    next_st.mode = pmwc_pkg::PM_RUN;
                    next_st.reg_mode = pmwc_pkg::REG_NORMAL;
                    next_st.fast_osc_en = 1'b1;
                    next_st.core_clk_en = 1'b1;
                    next_st.cpu_clk_en = 1'b1;
                end
            end
            pmwc_pkg::PM_STANDBY:
            begin
                if (stby_wake)
                begin
                    next_st.mode = pmwc_pkg::PM_RESET;
                    next_st.rst_cnt = 16'h0;
                    next_st.reg_mode = pmwc_pkg::REG_NORMAL;
                end
            end
            default:
            begin
                next_st.mode = pmwc_pkg::PM_RESET;
            end
        endcase

        // standby loses core state: volatile registers cleared
        if (st.mode == pmwc_pkg::PM_STANDBY)
        begin
            next_st.mask = 23'h0;
            next_st.rise = 23'h0;
            next_st.fall = 23'h0;
            next_st.pend = 23'h0;
            next_st.ctl = 6'h0;
            next_st.irq_st = 2'h0;
            next_st.irq_mk = 2'h0;
        end

        // low supply, reset pin or watchdog holds the core in reset, in any mode
        if (low_sup || pin_rst || wd_rst)
        begin
            next_st.mode = pmwc_pkg::PM_RESET;
            next_st.rst_cnt = 16'h0;
            next_st.core_rst = 1'b1;
            next_st.cpu_clk_en = 1'b0;
            next_st.reg_mode = pmwc_pkg::REG_NORMAL;
        end

        next_st.line_irq = st.pend & st.mask;
        next_st.irq = |(next_st.irq_st & next_st.irq_mk);
    end

    // single register for all state but the synchronisers; reset values mirror a cold start
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            st             <= '0;
            st.mode        <= pmwc_pkg::PM_RESET;
            st.reg_mode    <= pmwc_pkg::REG_NORMAL;
            st.core_rst    <= 1'b1;
            st.core_clk_en <= 1'b1;
            st.fast_osc_en <= 1'b1;
        end
        else if (i_ce)
        begin
            st <= next_st;
        end
    end

    // outputs straight from state flops; always-on clocks never gated
    assign o_awready     = !st.awvalid_done;
    assign o_wready      = !st.wvalid_done;
    assign o_bvalid      = st.bvalid;
    assign o_bresp       = st.bresp;
    assign o_arready     = !st.rvalid;
    assign o_rvalid      = st.rvalid;
    assign o_rdata       = st.rdata;
    assign o_rresp       = st.rresp;
    assign o_line_irq    = st.line_irq;
    assign o_irq         = st.irq;
    assign o_core_rst    = st.core_rst;
    assign o_cpu_clk_en  = st.cpu_clk_en;
    assign o_core_clk_en = st.core_clk_en;
    assign o_fast_osc_en = st.fast_osc_en;
    assign o_reg_mode    = st.reg_mode;
    assign o_aon_clk_en  = 1'b1;
    assign o_standby     = st.mode == pmwc_pkg::PM_STANDBY;

endmodule

// file: hdl/pmwc_cfg.svh
// constants for the power mode and wakeup controller
`ifndef PMWC_CFG_SVH
`define PMWC_CFG_SVH
`define PMWC_NUM_LINES    23
`define PMWC_NUM_PIN      16
`define PMWC_LINE_SUPPLY  16
`define PMWC_LINE_CAL     17
`define PMWC_LINE_USB     18
`define PMWC_LINE_CMP     19
`define PMWC_OFS_MASK     8'h00
`define PMWC_OFS_RISE     8'h04
`define PMWC_OFS_FALL     8'h08
`define PMWC_OFS_PEND     8'h0C
`define PMWC_OFS_PWRCTL   8'h10
`define PMWC_OFS_PWRSTAT  8'h14
`define PMWC_OFS_IRQSTAT  8'h18
`define PMWC_OFS_IRQMASK  8'h1C
`define PMWC_CTL_MON_EN   0
`define PMWC_CTL_MON_FALL 1
`define PMWC_CTL_MON_RISE 2
`define PMWC_CTL_DEEP     3
`define PMWC_CTL_LPREG    4
`define PMWC_CTL_STBY     5
`define PMWC_RST_NS       1000
`define PMWC_CLK_NS       50
`define PMWC_RST_CYC      ((`PMWC_RST_NS + `PMWC_CLK_NS - 1) / `PMWC_CLK_NS)
`endif

// file: hdl/pmwc_pkg.sv
// types for the power mode and wakeup controller
package pmwc_pkg;
    typedef enum logic [2:0] {PM_RESET, PM_RUN, PM_SLEEP, PM_DEEP, PM_STANDBY} pmwc_mode_e;
    typedef enum logic [1:0] {REG_NORMAL, REG_LOWPWR, REG_OFF} pmwc_reg_e;
    typedef struct packed {
        pmwc_mode_e  mode;
        logic [15:0] rst_cnt;
        logic [22:0] mask;
        logic [22:0] rise;
        logic [22:0] fall;
        logic [22:0] pend;
        logic [22:0] line_q;
        logic [5:0]  ctl;
        logic        mon_q;
        logic [1:0]  irq_st;
        logic [1:0]  irq_mk;
        logic        wk_q;
        logic        awvalid_done;
        logic        wvalid_done;
        logic [7:0]  waddr;
        logic [31:0] wdata;
        logic        bvalid;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  bresp;
        logic        core_rst;
        logic        cpu_clk_en;
        logic        core_clk_en;
        logic        fast_osc_en;
        pmwc_reg_e   reg_mode;
        logic        irq;
        logic [22:0] line_irq;
    } pmwc_state_s;
endpackage

// file: verif/pmwc_core_model.sv
// processor core model that issues wait-for-interrupt pulses
`timescale 1ns/1ns
module pmwc_core_model
(
    input  wire logic i_mclk,             // system clock
    input  wire logic i_cpu_clk_en,       // processor clock running
    input  wire logic i_go,               // bench asks for a sleep entry
    output logic      o_sleep_req = 1'b0  // one-cycle sleep pulse
);
    // no pulse while the cpu clock is stopped
    always_ff @(posedge i_mclk)
    begin
        o_sleep_req <= i_go && i_cpu_clk_en && !o_sleep_req;
    end
endmodule

// file: verif/pmwc_properties.sv
// port assertions for the power mode and wakeup controller
`timescale 1ns/1ns
module pmwc_properties
#(
    parameter int RST_CYC = 20
)
(
    input wire logic       i_mclk,        // system clock
    input wire logic       i_rst,         // synchronous reset
    input wire logic       i_low_supply,  // low-supply flag
    input wire logic       i_reset_pin_n, // reset pin, active low
    input wire logic       i_wdog_reset,  // watchdog reset
    input wire logic       i_wakeup_pin,  // wakeup pin
    input wire logic       i_cal_alarm,   // calendar alarm
    input wire logic       o_core_rst,    // core reset
    input wire logic       o_cpu_clk_en,  // processor clock
    input wire logic       o_core_clk_en, // core clocks
    input wire logic       o_fast_osc_en, // fast oscillators
    input wire logic [1:0] o_reg_mode,    // regulator mode
    input wire logic       o_aon_clk_en,  // always-on clocks
    input wire logic       o_standby      // standby flag
);
    // current core reset length
    logic [15:0] rst_len;
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            rst_len <= 16'h1;
        else if (o_core_rst)
            rst_len <= rst_len + 16'h1;
        else
            rst_len <= 16'h0;
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // standby, no wake source; sync needs cycles to drain
    sequence s_quiet;
        o_standby && i_reset_pin_n && !i_wdog_reset && !i_wakeup_pin && !i_cal_alarm && !i_low_supply;
    endsequence
    sequence s_rst_hold;
        o_core_rst [*2];
    endsequence

    a_reg_after_rst: assert property (($fell(i_rst) || $fell(o_core_rst)) |-> o_reg_mode == 2'h0)
        else $error("reg mode not normal");
    a_lowreg_deep_only: assert property (o_reg_mode == 2'h1 |-> !o_core_clk_en && !o_standby)
        else $error("low-power reg outside deep");
    a_standby_off: assert property (o_standby [*2] |-> o_reg_mode == 2'h2 && !o_fast_osc_en && !o_core_clk_en)
        else $error("standby power still on");
    a_deep_stops_all: assert property (!o_core_clk_en |-> !o_cpu_clk_en && !o_fast_osc_en)
        else $error("fast clocks without core");
    a_sleep_cpu_only: assert property (o_core_clk_en && !o_cpu_clk_en && !o_core_rst |-> o_fast_osc_en && o_reg_mode == 2'h0)
        else $error("sleep stopped too much");
    a_aon_running: assert property (o_aon_clk_en)
        else $error("always-on clocks stopped");
    a_low_supply_hold: assert property (i_low_supply [*5] |-> o_core_rst)
        else $error("no reset on low supply");
    a_rst_length: assert property ($fell(o_core_rst) |-> rst_len >= 16'(RST_CYC))
        else $error("core reset too short");
    a_standby_exit: assert property (s_quiet [*6] |=> o_standby)
        else $error("standby left unprompted");
    a_standby_reset: assert property ($fell(o_standby) |-> ##[0:2] s_rst_hold)
        else $error("no reset after standby");
    a_resume_cpu: assert property ($fell(o_core_rst) |-> o_cpu_clk_en && o_core_clk_en && o_fast_osc_en)
        else $error("cpu not resumed");
endmodule

bind pmwc_top pmwc_properties #(.RST_CYC(RST_CYC)) u_props (.*);

// file: verif/testbench.sv
// register-level testbench for the power mode and wakeup controller
`timescale 1ns/1ns
`include "pmwc_cfg.svh"
module testbench;
    localparam int RSTC = 4;
    logic i_mclk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_low_supply = 1'b0, i_supply_below = 1'b0;
    logic i_reset_pin_n = 1'b1, i_wdog_reset = 1'b0, i_wakeup_pin = 1'b0, go = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, rd;
    logic [3:0] i_wstrb = 4'hF;
    logic [22:0] src = 23'h0;
    logic [1:0] resp;
    wire [15:0] i_pin_lines = src[15:0];
    wire i_cal_alarm = src[17], i_usb_wake = src[18], i_cmp_wake = src[19];
    wire [2:0] i_int_lines = src[22:20];
    wire i_sleep_req, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_core_rst, o_standby;
    wire o_cpu_clk_en, o_core_clk_en, o_fast_osc_en, o_aon_clk_en;
    wire [1:0] o_bresp, o_rresp, o_reg_mode;
    wire [31:0] o_rdata;
    wire [22:0] o_line_irq;
    int n_fail = 0, tests_run = 0, i, j;

    pmwc_top #(.RST_CYC(RSTC)) u_dut (.*);
    pmwc_core_model u_core (.i_mclk(i_mclk), .i_cpu_clk_en(o_cpu_clk_en), .i_go(go), .o_sleep_req(i_sleep_req));

    // free-running system clock
    initial forever #25 i_mclk = ~i_mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // bus write, both channels at once
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int k;
        @(posedge i_mclk);
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_awaddr <= a;
        i_wdata <= d;
        i_bready <= 1'b1;
        tb = 1'b0;
        for (k = 0; k < 40 && !tb; k++)
        begin
            @(negedge i_mclk);
            ta = i_awvalid && o_awready;
            tw = i_wvalid && o_wready;
            tb = o_bvalid;
            resp = o_bresp;
            @(posedge i_mclk);
            if (ta) i_awvalid <= 1'b0;
            if (tw) i_wvalid <= 1'b0;
        end
        i_bready <= 1'b0;
        if (!tb) n_fail++;
    endtask

    // bus read; a missing answer counts as a mismatch
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic ta, tr;
        int k;
        @(posedge i_mclk);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        tr = 1'b0;
        for (k = 0; k < 40 && !tr; k++)
        begin
            @(negedge i_mclk);
            ta = i_arvalid && o_arready;
            tr = o_rvalid;
            rd = o_rdata;
            resp = o_rresp;
            @(posedge i_mclk);
            if (ta) i_arvalid <= 1'b0;
        end
        i_rready <= 1'b0;
        if (!tr) n_fail++;
        chk(rd, e);
    endtask

    // toggle a source, let it settle
    task automatic tg(input int n);
        @(posedge i_mclk);
        src[n] <= ~src[n];
        repeat (6) @(negedge i_mclk);
    endtask

    // bounded wait for a cpu clock level
    task automatic wcpu(input logic v);
        int k;
        @(negedge i_mclk);
        for (k = 0; k < 200 && o_cpu_clk_en !== v; k++)
            @(negedge i_mclk);
    endtask

    task automatic slp();
        @(posedge i_mclk);
        go <= 1'b1;
        @(posedge i_mclk);
        go <= 1'b0;
        wcpu(1'b0);
    endtask

    task automatic give_verdict();
        $display("runs %0d fails %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (10) @(posedge i_mclk);
        i_rst <= 1'b0;
        wcpu(1'b1);
        chk(32'({o_core_rst, o_reg_mode, o_aon_clk_en, o_core_clk_en, o_fast_osc_en}), 32'h7);
        rc(`PMWC_OFS_PWRCTL, 32'h0);
        rc(8'h40, 32'h0);
        chk(32'(resp), 32'h2);
        $display("test reset done");
        axw(`PMWC_OFS_MASK, 32'h007FFFFF);
        axw(`PMWC_OFS_RISE, 32'h007FFFFF);
        for (i = 0; i < 23; i++)
            if (i != `PMWC_LINE_SUPPLY)
            begin
                tg(i);
                chk(32'(o_line_irq), 32'h1 << i);
                rc(`PMWC_OFS_PEND, 32'h1 << i);
                axw(`PMWC_OFS_PEND, 32'h1 << i);
                tg(i);
                rc(`PMWC_OFS_PEND, 32'h0);
            end
        axw(`PMWC_OFS_RISE, 32'h0);
        axw(`PMWC_OFS_FALL, 32'h007FFFFF);
        tg(0);
        tg(0);
        rc(`PMWC_OFS_PEND, 32'h1);
        axw(`PMWC_OFS_PEND, 32'h1);
        axw(`PMWC_OFS_MASK, 32'h007FFFFE);
        tg(0);
        tg(0);
        chk(32'(o_line_irq), 32'h0);
        rc(`PMWC_OFS_PEND, 32'h0);
        axw(`PMWC_OFS_RISE, 32'h007FFFFF);
        axw(`PMWC_OFS_MASK, 32'h007FFFFF);
        $display("test lines done");
        axw(`PMWC_OFS_IRQMASK, 32'h3);
        i_supply_below <= 1'b1;
        repeat (6) @(negedge i_mclk);
        chk(32'(o_irq), 32'h0);
        rc(`PMWC_OFS_IRQSTAT, 32'h0);
        i_supply_below <= 1'b0;
        axw(`PMWC_OFS_PWRCTL, 32'h7);
        i_supply_below <= 1'b1;
        repeat (6) @(negedge i_mclk);
        chk(32'(o_irq), 32'h1);
        rc(`PMWC_OFS_IRQSTAT, 32'h1);
        rc(`PMWC_OFS_PWRSTAT, 32'h10);
        axw(`PMWC_OFS_IRQSTAT, 32'h1);
        i_supply_below <= 1'b0;
        repeat (6) @(negedge i_mclk);
        rc(`PMWC_OFS_IRQSTAT, 32'h2);
        axw(`PMWC_OFS_IRQMASK, 32'h0);
        repeat (3) @(negedge i_mclk);
        chk(32'(o_irq), 32'h0);
        axw(`PMWC_OFS_PWRCTL, 32'h0);
        axw(`PMWC_OFS_IRQSTAT, 32'h3);
        axw(`PMWC_OFS_PEND, 32'h007FFFFF);
        $display("test monitor done");
        slp();
        chk(32'({o_cpu_clk_en, o_core_clk_en, o_fast_osc_en, o_reg_mode}), 32'hC);
        rc(`PMWC_OFS_PWRSTAT, 32'h1);
        tg(5);
        wcpu(1'b1);
        chk(32'(o_cpu_clk_en), 32'h1);
        axw(`PMWC_OFS_PEND, 32'h007FFFFF);
        axw(`PMWC_OFS_MASK, 32'h0);
        for (j = 0; j < 2; j++)
        begin
            axw(`PMWC_OFS_PWRCTL, j ? 32'h18 : 32'h08);
            slp();
            chk(32'({o_core_clk_en, o_fast_osc_en, o_reg_mode}), 32'(j));
            tg(18 + j);
            wcpu(1'b1);
            chk(32'(o_cpu_clk_en), 32'h1);
        end
        rc(`PMWC_OFS_PWRCTL, 32'h18);
        $display("test sleep done");
        for (j = 0; j < 4; j++)
        begin
            axw(`PMWC_OFS_MASK, 32'h007FFFFF);
            axw(`PMWC_OFS_PWRCTL, 32'h20);
            slp();
            chk(32'({o_standby, o_reg_mode, o_fast_osc_en, o_aon_clk_en}), 32'h19);
            tg(3);
            repeat (6) @(negedge i_mclk);
            chk(32'(o_standby), 32'h1);
            @(posedge i_mclk);
            case (j)
                0: i_reset_pin_n <= 1'b0;
                1: i_wdog_reset <= 1'b1;
                2: i_wakeup_pin <= 1'b1;
                default: src[`PMWC_LINE_CAL] <= 1'b1;
            endcase
            repeat (4) @(posedge i_mclk);
            i_reset_pin_n <= 1'b1;
            i_wdog_reset <= 1'b0;
            i_wakeup_pin <= 1'b0;
            src[`PMWC_LINE_CAL] <= 1'b0;
            wcpu(1'b1);
            chk(32'({o_standby, o_core_rst}), 32'h0);
            rc(`PMWC_OFS_PWRCTL, 32'h0);
            rc(`PMWC_OFS_MASK, 32'h0);
        end
        $display("test standby done");
        @(posedge i_mclk);
        i_low_supply <= 1'b1;
        repeat (30) @(negedge i_mclk);
        chk(32'({o_core_rst, o_cpu_clk_en}), 32'h2);
        @(posedge i_mclk);
        i_low_supply <= 1'b0;
        wcpu(1'b1);
        chk(32'(o_core_rst), 32'h0);
        $display("test low supply done");
        give_verdict();
    end

    // hang guard
    initial
    begin
        #1000000;
        n_fail++;
        give_verdict();
    end
endmodule
